// file: start_seq_pkg.sv
package start_seq_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_TEST_LEN = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RESULT = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  localparam logic [7:0] REG_FLOW = 8'h1c;

  // Control and command fields
  localparam int CTRL_CONT_BIT = 0;
  localparam int CTRL_CLEAN_BIT = 1;
  localparam int CTRL_TMODE_LSB = 2;
  localparam int CTRL_AMODE_LSB = 4;
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_STOP_BIT = 1;

  // Status and interrupt fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_LEVEL_BIT = 1;
  localparam int ST_FAULT_BIT = 2;
  localparam int ST_CLEAN_BIT = 3;
  localparam int ST_VALID_BIT = 4;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ABORT_BIT = 1;
  localparam int IRQ_FAULT_BIT = 2;
  localparam int IRQ_W = 3;

  // Reset values
  localparam logic [5:0] CTRL_RST = 6'h04;
  localparam logic [23:0] TEST_LEN_RST = 24'h0003e8;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // Flow working range, ml/min
  localparam logic [15:0] FLOW_MIN_MLMIN = 16'h0014;
  localparam logic [15:0] FLOW_MAX_MLMIN = 16'h0190;

  // Start input debounce
  localparam int CLK_MHZ = 125;
  localparam int DEBOUNCE_US = 10000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;

  typedef enum logic [1:0] {
    TM_OFF = 2'b00,
    TM_LEVEL = 2'b01,
    TM_EDGE = 2'b10,
    TM_RSVD = 2'b11
  } test_mode_t;

  typedef enum logic [1:0] {
    AM_OFF = 2'b00,
    AM_RESULT = 2'b01,
    AM_RUN = 2'b10,
    AM_RSVD = 2'b11
  } alarm_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } seq_state_t;

endpackage

// file: start_debounce.sv
`timescale 1ns/1ns
module start_debounce #(
  parameter int Cycles = 1250000,
  parameter int CntW = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Raw isolated input and clean level
  input wire logic rawIn,
  output logic levelOut
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic stable;
    logic [CntW-1:0] cnt;
  } deb_state_t;

  localparam logic [CntW-1:0] LAST = CntW'(Cycles - 1);

  deb_state_t s_r;
  deb_state_t s_nxt;

  if (Cycles < 1 || Cycles > (2 ** CntW)) begin : g_chk
    $error("start_debounce: Cycles does not fit CntW");
  end

  // Level changes only after it has held for the full window [R14]
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync1 = rawIn;
    s_nxt.sync2 = s_r.sync1;
    if (s_r.sync2 == s_r.stable) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt == LAST) begin
      s_nxt.stable = s_r.sync2;
      s_nxt.cnt = '0;
    end else begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign levelOut = s_r.stable;

endmodule

// file: test_start_sequencer.sv
`timescale 1ns/1ns
//  Contract
// [R1] Start input rising begins a test, or restarts the running one.
// [R2] At test completion the start level is sampled to pick what follows.
// [R3] Start still on at completion launches another test straight away.
// [R4] Start input falling aborts the running test.
// [R5] After an abort the last completed result stays shown and reported.
// [R6] Start-driven behaviour is the same with continuous testing on or off.
// [R7] Continuous plus stop-when-clean: held start ends on drop or clean.
// [R8] Flow is checked during each test; out of range raises a fault.
// [R9] Results taken with out-of-range flow are never logged.
// [R10] Flow is in range only from 20 to 400 ml/min inclusive.
// [R11] Test-mode setting selects what the start input does.
// [R12] Alarm-mode setting selects what the two alarm outputs show.
// [R13] Controller holds start as a level for the whole wanted period.
// [R14] Start input is synchronised and debounced before edge detection.
module test_start_sequencer #(
  parameter int DebounceCycles = start_seq_pkg::DEBOUNCE_CYCLES,
  parameter int CntW = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Isolated start input
  input wire logic startIn,
  // Measurement engine
  input wire logic [15:0] flowRate,
  input wire logic [15:0] resultCode,
  input wire logic resultClean,
  // Test sequencing
  output logic testRun,
  output logic testStart,
  output logic testAbort,
  // Result log and display
  output logic logWrite,
  output logic [15:0] logData,
  output logic [15:0] resultShown,
  output logic flowFault,
  // Alarm outputs and interrupt
  output logic alarmOut1,
  output logic alarmOut2,
  output logic irq
);
  import start_seq_pkg::*;

  typedef struct packed {
    seq_state_t state;
    logic running;
    logic [CntW-1:0] cnt;
    logic [CntW-1:0] testLen;
    logic [5:0] ctrl;
    logic lvlPrev;
    logic flowBad;
    logic [15:0] result;
    logic resultValid;
    logic lastClean;
    logic lastFault;
    logic startPulse;
    logic abortPulse;
    logic logWr;
    logic [15:0] logVal;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic irqOut;
    logic al1;
    logic al2;
    logic [31:0] rdata;
    logic rdy;
    logic err;
  } seq_regs_t;

  seq_regs_t s_r;
  seq_regs_t s_nxt;
  logic startLvl;

  // Reset test length must fit the counter
  if (CntW < 10 || CntW > 32) begin : g_chk
    $error("test_start_sequencer: CntW out of range");
  end

  function automatic logic flowInRange(input logic [15:0] f);
    flowInRange = (f >= FLOW_MIN_MLMIN) && (f <= FLOW_MAX_MLMIN); // [R10]
  endfunction

  function automatic logic addrMapped(input logic [7:0] a);
    case (a)
      REG_CTRL, REG_CMD, REG_TEST_LEN, REG_STATUS, REG_RESULT,
      REG_IRQ_STAT, REG_IRQ_MASK, REG_FLOW: addrMapped = 1'b1;
      default: addrMapped = 1'b0;
    endcase
  endfunction

  // Relies on the controller holding start as a steady level [R13]
  start_debounce #(
    .Cycles(DebounceCycles),
    .CntW(CntW)
  ) u_deb (
    .clk(clk),
    .reset(reset),
    .rawIn(startIn),
    .levelOut(startLvl)
  );

  test_mode_t tMode;
  alarm_mode_t aMode;
  logic wrEn;
  logic goCmd;
  logic stopCmd;
  logic rise;
  logic fall;
  logic abortNow;
  logic complete;
  logic badNow;
  logic holdRepeat;
  logic contRepeat;
  logic cleanStop;

  assign tMode = test_mode_t'(s_r.ctrl[CTRL_TMODE_LSB +: 2]);
  assign aMode = alarm_mode_t'(s_r.ctrl[CTRL_AMODE_LSB +: 2]);
  assign wrEn = psel && penable && s_r.rdy && pwrite;
  assign goCmd = wrEn && (paddr == REG_CMD) && pwdata[CMD_GO_BIT];
  assign stopCmd = wrEn && (paddr == REG_CMD) && pwdata[CMD_STOP_BIT];
  // Start input ignored when mode is off [R11]
  assign rise = (tMode != TM_OFF) && startLvl && !s_r.lvlPrev;
  // Only level mode treats the drop as a stop [R4] [R11]
  assign fall = (tMode == TM_LEVEL) && !startLvl && s_r.lvlPrev;
  assign abortNow = (s_r.state == ST_RUN) && !rise && (fall || stopCmd);
  assign complete = (s_r.state == ST_RUN) && !rise && !abortNow &&
                    (s_r.cnt == s_r.testLen - 1'b1);
  assign badNow = s_r.flowBad || !flowInRange(flowRate); // [R8]
  // Held level repeats whatever the continuous setting is [R2] [R3] [R6]
  assign holdRepeat = (tMode == TM_LEVEL) && startLvl;
  assign contRepeat = s_r.ctrl[CTRL_CONT_BIT];
  assign cleanStop = s_r.ctrl[CTRL_CONT_BIT] && s_r.ctrl[CTRL_CLEAN_BIT] &&
                     resultClean; // [R7]

  always_comb begin
    logic [IRQ_W-1:0] irqSet;
    logic [IRQ_W-1:0] irqClr;
    irqSet = '0;
    irqClr = '0;
    s_nxt = s_r;
    s_nxt.startPulse = 1'b0;
    s_nxt.abortPulse = 1'b0;
    s_nxt.logWr = 1'b0;
    s_nxt.lvlPrev = startLvl;

    if (rise) begin
      s_nxt.state = ST_RUN; // [R1]
      s_nxt.cnt = '0;
      s_nxt.flowBad = 1'b0;
      s_nxt.startPulse = 1'b1;
    end else if (abortNow) begin
      // Result fields untouched, so the previous result stays [R4] [R5]
      s_nxt.state = ST_IDLE;
      s_nxt.abortPulse = 1'b1;
      irqSet[IRQ_ABORT_BIT] = 1'b1;
    end else if (complete) begin
      s_nxt.result = resultCode;
      s_nxt.resultValid = 1'b1;
      s_nxt.lastClean = resultClean;
      s_nxt.lastFault = badNow; // [R8]
      s_nxt.logWr = !badNow; // [R9]
      s_nxt.logVal = resultCode;
      irqSet[IRQ_DONE_BIT] = 1'b1;
      irqSet[IRQ_FAULT_BIT] = badNow;
      if ((holdRepeat || contRepeat) && !cleanStop) begin
        s_nxt.cnt = '0; // [R3] [R7]
        s_nxt.flowBad = 1'b0;
        s_nxt.startPulse = 1'b1;
      end else begin
        s_nxt.state = ST_IDLE;
      end
    end else if (s_r.state == ST_RUN) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
      s_nxt.flowBad = badNow; // [R8]
    end else if (goCmd) begin
      s_nxt.state = ST_RUN;
      s_nxt.cnt = '0;
      s_nxt.flowBad = 1'b0;
      s_nxt.startPulse = 1'b1;
    end

    // Register writes take effect at the access edge
    if (wrEn) begin
      case (paddr)
        REG_CTRL: s_nxt.ctrl = pwdata[5:0];
        REG_TEST_LEN: begin
          // Zero length would only complete once the counter reaches all ones; clamp to one cycle
          s_nxt.testLen = (pwdata[CntW-1:0] == '0) ?
                          CntW'(1) : pwdata[CntW-1:0];
        end
        REG_IRQ_STAT: irqClr = pwdata[IRQ_W-1:0];
        REG_IRQ_MASK: s_nxt.irqMask = pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    // A new event outweighs a clear in the same cycle
    s_nxt.irqStat = (s_r.irqStat & ~irqClr) | irqSet;
    s_nxt.irqOut = |(s_nxt.irqStat & s_nxt.irqMask);

    s_nxt.running = s_nxt.state == ST_RUN;

    // Alarm outputs follow the alarm mode [R12]
    case (aMode)
      AM_RESULT: begin
        s_nxt.al1 = s_nxt.resultValid && !s_nxt.lastClean;
        s_nxt.al2 = s_nxt.lastFault;
      end
      AM_RUN: begin
        s_nxt.al1 = s_nxt.state == ST_RUN;
        s_nxt.al2 = s_nxt.resultValid && !s_nxt.lastClean;
      end
      default: begin
        s_nxt.al1 = 1'b0;
        s_nxt.al2 = 1'b0;
      end
    endcase

    // Zero-wait slave: data is prepared in the setup cycle
    s_nxt.rdy = psel && !penable;
    s_nxt.err = psel && !penable && !addrMapped(paddr);
    s_nxt.rdata = '0;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        REG_CTRL: s_nxt.rdata = {26'h0, s_r.ctrl};
        REG_TEST_LEN: s_nxt.rdata = 32'(s_r.testLen);
        REG_STATUS: begin
          s_nxt.rdata[ST_BUSY_BIT] = s_r.state == ST_RUN;
          s_nxt.rdata[ST_LEVEL_BIT] = startLvl;
          s_nxt.rdata[ST_FAULT_BIT] = s_r.lastFault;
          s_nxt.rdata[ST_CLEAN_BIT] = s_r.lastClean;
          s_nxt.rdata[ST_VALID_BIT] = s_r.resultValid;
        end
        REG_RESULT: s_nxt.rdata = {16'h0, s_r.result};
        REG_IRQ_STAT: s_nxt.rdata = 32'(s_r.irqStat);
        REG_IRQ_MASK: s_nxt.rdata = 32'(s_r.irqMask);
        REG_FLOW: s_nxt.rdata = {16'h0, flowRate};
        default: s_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.state <= ST_IDLE;
      s_r.testLen <= CntW'(TEST_LEN_RST);
      s_r.ctrl <= CTRL_RST;
      s_r.irqMask <= IRQ_MASK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign pready = s_r.rdy;
  assign pslverr = s_r.err;
  assign testRun = s_r.running;
  assign testStart = s_r.startPulse;
  assign testAbort = s_r.abortPulse;
  assign logWrite = s_r.logWr;
  assign logData = s_r.logVal;
  assign resultShown = s_r.result;
  assign flowFault = s_r.lastFault;
  assign alarmOut1 = s_r.al1;
  assign alarmOut2 = s_r.al2;
  assign irq = s_r.irqOut;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_rise_restarts: assert property (rise |=> testRun && testStart &&
    s_r.cnt == '0) else $error("start rise did not restart test"); // [R1]

  a_fall_aborts: assert property (s_r.state == ST_RUN && fall && !rise
    |=> !testRun && testAbort) else $error("start drop did not abort"); // [R4]

  a_held_repeats: assert property (complete && holdRepeat && !cleanStop
    |=> testRun && testStart ##1 !testStart)
    else $error("held start did not repeat test"); // [R3]

  a_abort_keeps: assert property (testAbort |-> $stable(resultShown) &&
    $stable(flowFault)) else $error("abort changed shown result"); // [R5]

  a_clean_stops: assert property (complete && cleanStop && !contRepeat
    || complete && cleanStop |=> !testRun)
    else $error("clean result did not stop testing"); // [R7]

  a_bad_nolog: assert property (complete && !flowInRange(flowRate)
    |=> flowFault && !logWrite) else $error("bad flow logged"); // [R9]

  a_flow_fault: assert property (s_r.state == ST_RUN && !rise && !abortNow
    && !complete && !flowInRange(flowRate) |=> s_r.flowBad)
    else $error("out of range flow not flagged"); // [R8]

  a_mode_off: assert property (tMode == TM_OFF && s_r.state == ST_IDLE &&
    !goCmd |=> !testStart) else $error("start input acted when off"); // [R11]

  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb ready timing wrong");

  a_irq_mask: assert property ((s_r.irqStat & s_r.irqMask) == '0 |-> !irq)
    else $error("masked interrupt raised");

endmodule

// file: start_driver.sv
`timescale 1ns/1ns
module start_driver (
  // Clock and wanted level
  input wire logic clk,
  input wire logic wantOn,
  // Isolated start level
  output logic startIn
);
  initial startIn = 1'b0;
  // Held as a level, moved only on clock edges
  always @(posedge clk) begin
    startIn <= wantOn;
  end
endmodule

// file: testbench.sv
`timescale 1ns/1ns
module testbench;
  import start_seq_pkg::*;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, wantOn = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, startIn, testRun, testStart, testAbort;
  logic logWrite, flowFault, alarmOut1, alarmOut2, irq, resultClean = 0;
  logic [15:0] flowRate = 16'h00c8, resultCode = 16'h0011;
  logic [15:0] logData, resultShown;
  logic [15:0] flows [4] = '{16'h0013, 16'h0014, 16'h0190, 16'h0191};
  int errTotal = 0, nChecks = 0, nS, nL, nA, k;
  always #4 clk = ~clk;
  start_driver i_drv (.clk(clk), .wantOn(wantOn), .startIn(startIn));
  test_start_sequencer #(.DebounceCycles(4)) i_dut (.clk(clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .startIn(startIn), .flowRate(flowRate),
    .resultCode(resultCode), .resultClean(resultClean),
    .testRun(testRun), .testStart(testStart), .testAbort(testAbort),
    .logWrite(logWrite), .logData(logData), .resultShown(resultShown),
    .flowFault(flowFault), .alarmOut1(alarmOut1),
    .alarmOut2(alarmOut2), .irq(irq));
  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    k = 0;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      errTotal++;
      $display("mismatch at %0t: no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic setOn(input logic v);
    @(posedge clk);
    wantOn <= v;
  endtask
  // Pulse counts over a window, sampled mid-cycle
  task automatic watch(input int cyc);
    nS = 0;
    nL = 0;
    nA = 0;
    repeat (cyc) begin
      @(negedge clk);
      nS += (testStart === 1'b1);
      nL += (logWrite === 1'b1);
      nA += (testAbort === 1'b1);
    end
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    errTotal++;
    giveVerdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    reset <= 0;
    apb(0, REG_CTRL, 0);
    chk(rd, 32'h4);
    apb(0, REG_TEST_LEN, 0);
    chk(rd, 32'h3e8);
    apb(0, 8'h20, 32'h5);
    chk(err, 1);
    chk(rd, 32'h0);
    apb(1, REG_TEST_LEN, 32'h10);
    apb(1, REG_IRQ_MASK, 32'h7);
    setOn(1);
    watch(56);
    chk(nS == 3 && nL == 2 && nA == 0, 1);
    chk(logData, 16'h0011);
    k = 0;
    while (logWrite !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    chk(logWrite, 1);
    @(posedge clk);
    resultCode <= 16'h0022;
    wantOn <= 0;
    watch(12);
    chk(nA, 1);
    chk(resultShown, 16'h0011);
    chk(testRun, 0);
    apb(0, REG_RESULT, 0);
    chk(rd, 32'h11);
    apb(0, REG_IRQ_STAT, 0);
    chk(rd, 32'h3);
    chk(irq, 1);
    apb(1, REG_IRQ_MASK, 32'h0);
    @(negedge clk);
    chk(irq, 0);
    apb(1, REG_IRQ_STAT, 32'h3);
    apb(0, REG_IRQ_STAT, 0);
    chk(rd, 32'h0);
    apb(1, REG_IRQ_MASK, 32'h7);
    apb(1, REG_CTRL, 32'h5);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      flowRate <= flows[i];
      setOn(1);
      watch(28);
      chk(nL, (i == 1 || i == 2));
      chk(flowFault, (i == 0 || i == 3));
      setOn(0);
      watch(12);
      chk(nA, 1);
    end
    // Last result faulty and not clean: both alarms on in result mode
    apb(1, REG_CTRL, 32'h15);
    repeat (2) @(negedge clk);
    chk({alarmOut1, alarmOut2}, 2'b11);
    @(posedge clk);
    flowRate <= 16'h00c8;
    resultClean <= 1;
    apb(1, REG_CTRL, 32'h7);
    setOn(1);
    watch(34);
    chk(nS == 1 && nL == 1 && testRun === 1'b0, 1);
    setOn(0);
    watch(10);
    apb(1, REG_TEST_LEN, 32'h20);
    apb(1, REG_CTRL, 32'h28);
    setOn(1);
    watch(9);
    chk(nS, 1);
    chk(alarmOut1, 1);
    chk(alarmOut2, 0);
    setOn(0);
    watch(8);
    chk(nA == 0 && testRun === 1'b1, 1);
    setOn(1);
    watch(9);
    chk(nS == 1 && nL == 0, 1);
    setOn(0);
    watch(40);
    apb(1, REG_CTRL, 32'h0);
    setOn(1);
    watch(12);
    chk(nS, 0);
    apb(1, REG_CMD, 32'h1);
    @(negedge clk);
    chk(testStart, 1);
    apb(1, REG_CMD, 32'h2);
    @(negedge clk);
    chk(testAbort, 1);
    setOn(0);
    apb(1, REG_CTRL, 32'h4);
    watch(10);
    setOn(1);
    setOn(0);
    watch(12);
    chk(nS, 0);
    giveVerdict();
  end
endmodule
